// ==== core/css_pkg.sv ====
// Constants and types for the card session supply sequencer
package css_pkg;
    typedef enum logic [1:0] {
        CSS_IDLE,
        CSS_ACTIVATE,
        CSS_ACTIVE,
        CSS_DEACTIVATE
    } css_state_e;

    // System clock and internal oscillator
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 400;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STEP_OSC_PERIODS = 64;
    localparam int HALF_STEP_TICKS = STEP_OSC_PERIODS / 2;
    localparam int HALF_CNT_W = 5;

    // Sequence points in half steps
    localparam logic [3:0] ACT_IO_HALF = 4'h8;
    localparam logic [3:0] ACT_RST_HALF = 4'he;
    localparam logic [3:0] DEACT_HALVES = 4'h3;
    localparam logic [3:0] DEACT_CLK_HALF = 4'h2;
    localparam logic [3:0] DEACT_IO_HALF = 4'h1;

    // Supply reset pulse
    localparam int SUPPLY_RESET_PULSE_TIME_MS = 10;
    localparam int SUPPLY_RESET_PULSE_CYCLES =
        SUPPLY_RESET_PULSE_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // Clock window limits
    localparam int CLK_WIN_OPEN_MAX_US = 130;
    localparam int CLK_WIN_OPEN_MAX_CYC =
        CLK_WIN_OPEN_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CLK_WIN_CLOSE_MIN_US = 140;
    localparam int CLK_WIN_CLOSE_MIN_CYC =
        (CLK_WIN_CLOSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACT_CNT_W = 15;

    // Register map
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] INT_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] INT_MASK_OFFSET = 8'h0c;

    // Control fields
    localparam int CTRL_THR_SEL_BIT = 0;
    localparam int CTRL_DIV_LSB = 1;
    localparam logic [1:0] CTRL_DIV_RESET = 2'h0;

    // Status fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SUPPLY_OK_BIT = 4;
    localparam int ST_PULSE_BUSY_BIT = 5;
    localparam int ST_PRESENT_BIT = 6;
    localparam int ST_CLK_RUN_BIT = 7;

    // Interrupt bits
    localparam int INT_W = 3;
    localparam int INT_ACT_DONE_BIT = 0;
    localparam int INT_DEACT_DONE_BIT = 1;
    localparam int INT_SUPPLY_FAULT_BIT = 2;

    // Card clock divider select codes
    localparam logic [1:0] DIV_SEL_8 = 2'h0;
    localparam logic [1:0] DIV_SEL_4 = 2'h1;
    localparam logic [1:0] DIV_SEL_2 = 2'h3;
endpackage : css_pkg

// ==== core/css_sequencer.sv ====
// Supply supervisor and card contact sequencer with APB registers
`timescale 1ns/1ps
module css_sequencer
    import css_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES = SUPPLY_RESET_PULSE_CYCLES,
    parameter int OSC_DIVIDE = OSC_DIV
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Host command lines
    input wire logic i_activation_request_n,
    input wire logic i_card_reset_request,
    input wire logic i_card_present_in,
    input wire logic i_card_present_in_n,
    // Supply comparators, index by threshold select
    input wire logic [1:0] i_supply_above_upper,
    input wire logic [1:0] i_supply_below_lower,
    // Card contacts
    output logic o_card_vcc_en,
    output logic o_card_io_en,
    output logic o_card_clk,
    output logic o_card_rst,
    // Status
    output logic o_supply_ready,
    output logic o_irq
);
    localparam int PW = $clog2(RESET_PULSE_CYCLES + 1);
    localparam int OW = $clog2(OSC_DIVIDE + 1);
    localparam int GW = $clog2(HALF_STEP_TICKS * OSC_DIVIDE);

    typedef struct packed {
        logic req_n_s1;
        logic req_n_s2;
        logic rst_s1;
        logic rst_s2;
        logic card_present_in_s1;
        logic card_present_in_s2;
        logic card_present_in_n_s1;
        logic card_present_in_n_s2;
        logic above_s1;
        logic above_s2;
        logic below_s1;
        logic below_s2;
        logic supply_ok;
        logic pulse_busy;
        logic [PW-1:0] pulse_cnt;
        css_state_e state;
        logic [OW-1:0] osc_cnt;
        logic [HALF_CNT_W-1:0] tick_cnt;
        logic [3:0] half_idx;
        logic vcc_en;
        logic io_en;
        logic clk_run;
        logic card_rst;
        logic [2:0] div_cnt;
        logic [1:0] div_k;
        logic clk_gate;
        logic card_clk;
        logic [ACT_CNT_W-1:0] act_cnt;
        logic thr_sel;
        logic [1:0] div_sel;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic irq;
        logic [31:0] prdata;
        logic [GW-1:0] gap_cnt;
    } css_st_s;

    css_st_s st_reg;
    css_st_s st_next;
    logic present;
    logic osc_tick;
    logic half_tick;
    logic go_deact;
    logic div_wrap;
    logic [3:0] div_len;
    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] w1c;
    logic apb_acc;
    logic apb_wr;
    logic mapped;
    logic [31:0] rd;

    // Register bus decode; zero wait states
    assign apb_acc = i_psel & i_penable;
    assign apb_wr = apb_acc & i_pwrite;
    assign mapped = (i_paddr == CTRL_OFFSET) || (i_paddr == STATUS_OFFSET)
        || (i_paddr == INT_STATUS_OFFSET) || (i_paddr == INT_MASK_OFFSET);
    assign o_pready = 1'b1;
    assign o_pslverr = apb_acc & ~mapped;

    // Both presence polarities count as a card in place
    assign present = st_reg.card_present_in_s2 | ~st_reg.card_present_in_n_s2;

    // Internal oscillator tick and half step pulse
    assign osc_tick = st_reg.osc_cnt == OW'(OSC_DIVIDE - 1);
    assign half_tick = osc_tick
        && st_reg.tick_cnt == HALF_CNT_W'(HALF_STEP_TICKS - 1);

    // Card clock divider period, power of two for a clean half duty
    assign div_len = 4'h1 << st_reg.div_k;
    assign div_wrap = {1'b0, st_reg.div_cnt} == div_len - 4'h1;

    // Read data mux
    always_comb
    begin
        rd = 32'h0;
        case (i_paddr)
            CTRL_OFFSET:
            begin
                rd[CTRL_THR_SEL_BIT] = st_reg.thr_sel;
                rd[CTRL_DIV_LSB +: 2] = st_reg.div_sel;
            end
            STATUS_OFFSET:
            begin
                rd[ST_STATE_LSB +: 2] = st_reg.state;
                rd[ST_SUPPLY_OK_BIT] = st_reg.supply_ok;
                rd[ST_PULSE_BUSY_BIT] = st_reg.pulse_busy;
                rd[ST_PRESENT_BIT] = present;
                rd[ST_CLK_RUN_BIT] = st_reg.clk_gate;
            end
            INT_STATUS_OFFSET: rd[INT_W-1:0] = st_reg.int_stat;
            INT_MASK_OFFSET: rd[INT_W-1:0] = st_reg.int_mask;
            default: rd = 32'h0;
        endcase
    end

    // Next state of the whole block
    always_comb
    begin
        st_next = st_reg;
        ev = '0;
        w1c = '0;
        go_deact = 1'b0;
        // Two flops per host line; first stage feeds only the second
        st_next.req_n_s1 = i_activation_request_n;
        st_next.req_n_s2 = st_reg.req_n_s1;
        st_next.rst_s1 = i_card_reset_request;
        st_next.rst_s2 = st_reg.rst_s1;
        st_next.card_present_in_s1 = i_card_present_in;
        st_next.card_present_in_s2 = st_reg.card_present_in_s1;
        st_next.card_present_in_n_s1 = i_card_present_in_n;
        st_next.card_present_in_n_s2 = st_reg.card_present_in_n_s1;
        st_next.above_s1 = i_supply_above_upper[st_reg.thr_sel];
        st_next.above_s2 = st_reg.above_s1;
        st_next.below_s1 = i_supply_below_lower[st_reg.thr_sel];
        st_next.below_s2 = st_reg.below_s1;

        // Supervisor: hysteresis band keeps the current verdict
        if (st_reg.below_s2)
        begin
            st_next.supply_ok = 1'b0;
            st_next.pulse_busy = 1'b0;
            st_next.pulse_cnt = '0;
        end
        else if (!st_reg.supply_ok)
        begin
            if (!st_reg.above_s2)
            begin
                st_next.pulse_busy = 1'b0;
                st_next.pulse_cnt = '0;
            end
            else if (st_reg.pulse_cnt == PW'(RESET_PULSE_CYCLES - 1))
            begin
                st_next.supply_ok = 1'b1;
                st_next.pulse_busy = 1'b0;
                st_next.pulse_cnt = '0;
            end
            else
            begin
                st_next.pulse_busy = 1'b1;
                st_next.pulse_cnt = st_reg.pulse_cnt + PW'(1);
            end
        end

        // Step timing free-runs; restarted at each sequence entry
        st_next.osc_cnt = osc_tick ? '0 : st_reg.osc_cnt + OW'(1);
        if (osc_tick)
        begin
            st_next.tick_cnt = half_tick ? '0 : st_reg.tick_cnt + 1'b1;
        end
        if (st_reg.state == CSS_ACTIVATE && !(&st_reg.act_cnt))
        begin
            st_next.act_cnt = st_reg.act_cnt + 1'b1;
        end

        // Contact sequencer
        case (st_reg.state)
            CSS_IDLE:
            begin
                // Commands ignored until supply and pulse are done
                if (st_reg.supply_ok && !st_reg.req_n_s2 && present)
                begin
                    st_next.state = CSS_ACTIVATE;
                    st_next.half_idx = '0;
                    st_next.osc_cnt = '0;
                    st_next.tick_cnt = '0;
                    st_next.act_cnt = '0;
                    st_next.vcc_en = 1'b1;
                end
            end
            CSS_ACTIVATE:
            begin
                if (!st_reg.supply_ok || st_reg.req_n_s2)
                begin
                    go_deact = 1'b1;
                end
                else
                begin
                    if (half_tick)
                    begin
                        st_next.half_idx = st_reg.half_idx + 4'h1;
                    end
                    // Window opens with the data lines at 4 steps
                    if (st_next.half_idx >= ACT_IO_HALF)
                    begin
                        st_next.io_en = 1'b1;
                    end
                    // Clock starts once reset request is low in window
                    if (st_reg.io_en && !st_reg.rst_s2)
                    begin
                        st_next.clk_run = 1'b1;
                    end
                    // At 7 steps the window closes and reset follows
                    if (st_next.half_idx == ACT_RST_HALF)
                    begin
                        st_next.state = CSS_ACTIVE;
                        st_next.clk_run = 1'b1;
                        ev[INT_ACT_DONE_BIT] = 1'b1;
                    end
                end
            end
            CSS_ACTIVE:
            begin
                if (!st_reg.supply_ok || st_reg.req_n_s2)
                begin
                    go_deact = 1'b1;
                end
                else
                begin
                    st_next.card_rst = st_reg.rst_s2;
                end
            end
            CSS_DEACTIVATE:
            begin
                // Counting back down: clock, then lines, then supply
                if (half_tick)
                begin
                    st_next.half_idx = st_reg.half_idx - 4'h1;
                    if (st_next.half_idx <= DEACT_CLK_HALF)
                    begin
                        st_next.clk_run = 1'b0;
                    end
                    if (st_next.half_idx <= DEACT_IO_HALF)
                    begin
                        st_next.io_en = 1'b0;
                    end
                    if (st_next.half_idx == 4'h0)
                    begin
                        st_next.vcc_en = 1'b0;
                        st_next.state = CSS_IDLE;
                        ev[INT_DEACT_DONE_BIT] = 1'b1;
                    end
                end
            end
            default:
            begin
                st_next.state = CSS_IDLE;
            end
        endcase

        // Any exit from a session, supply loss included
        if (go_deact)
        begin
            st_next.state = CSS_DEACTIVATE;
            st_next.half_idx = DEACT_HALVES;
            st_next.osc_cnt = '0;
            st_next.tick_cnt = '0;
            st_next.card_rst = 1'b0;
            ev[INT_SUPPLY_FAULT_BIT] = ~st_reg.supply_ok;
        end

        // Card clock changes rate and gate only at a period boundary
        if (div_wrap)
        begin
            st_next.div_cnt = 3'h0;
            st_next.clk_gate = st_reg.clk_run;
            case (st_reg.div_sel)
                DIV_SEL_8: st_next.div_k = 2'h3;
                DIV_SEL_4: st_next.div_k = 2'h2;
                DIV_SEL_2: st_next.div_k = 2'h1;
                default: st_next.div_k = 2'h1; // Fastest the flops allow
            endcase
        end
        else
        begin
            st_next.div_cnt = st_reg.div_cnt + 3'h1;
        end
        st_next.card_clk = st_next.clk_gate
            && ({1'b0, st_next.div_cnt} < ((4'h1 << st_next.div_k) >> 1));
        // Cycles into the current half step, watched by the step check
        st_next.gap_cnt = (st_next.osc_cnt == '0 && st_next.tick_cnt == '0)
            ? '0 : st_reg.gap_cnt + GW'(1);

        // Registers: writes act on the access edge
        if (apb_wr && i_paddr == CTRL_OFFSET)
        begin
            st_next.thr_sel = i_pwdata[CTRL_THR_SEL_BIT];
            st_next.div_sel = i_pwdata[CTRL_DIV_LSB +: 2];
        end
        if (apb_wr && i_paddr == INT_MASK_OFFSET)
        begin
            st_next.int_mask = i_pwdata[INT_W-1:0];
        end
        if (apb_wr && i_paddr == INT_STATUS_OFFSET)
        begin
            w1c = i_pwdata[INT_W-1:0];
        end
        // Set wins over a clear in the same cycle
        st_next.int_stat = (st_reg.int_stat & ~w1c) | ev;
        st_next.irq = |(st_next.int_stat & st_next.int_mask);
        // Read data captured in setup, stable through access
        if (i_psel && !i_penable)
        begin
            st_next.prdata = rd;
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            st_reg <= '0;
            st_reg.req_n_s1 <= 1'b1;
            st_reg.req_n_s2 <= 1'b1;
            st_reg.card_present_in_n_s1 <= 1'b1;
            st_reg.card_present_in_n_s2 <= 1'b1;
            st_reg.div_k <= 2'h3;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign o_prdata = st_reg.prdata;
    assign o_card_vcc_en = st_reg.vcc_en;
    assign o_card_io_en = st_reg.io_en;
    assign o_card_clk = st_reg.card_clk;
    assign o_card_rst = st_reg.card_rst;
    assign o_supply_ready = st_reg.supply_ok;
    assign o_irq = st_reg.irq;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    chk_idle_hold: assert property (
        !st_reg.supply_ok && st_reg.state == CSS_IDLE
        |=> st_reg.state == CSS_IDLE)
        else $error("left idle without supply");
    chk_pulse_len: assert property (
        $rose(st_reg.supply_ok)
        |-> $past(st_reg.pulse_cnt) == PW'(RESET_PULSE_CYCLES - 1))
        else $error("supply ready before pulse end");
    chk_fault_deact: assert property (
        (st_reg.state == CSS_ACTIVATE || st_reg.state == CSS_ACTIVE)
        && st_reg.below_s2 |-> ##2 st_reg.state == CSS_DEACTIVATE)
        else $error("no deactivation on supply drop");
    chk_power_quiet: assert property (
        !st_reg.supply_ok && st_reg.state == CSS_IDLE
        |-> !o_card_vcc_en && !o_card_io_en && !o_card_clk && !o_card_rst)
        else $error("contact active without supply");
    chk_window_open: assert property (
        $rose(o_card_io_en)
        |-> st_reg.act_cnt <= ACT_CNT_W'(CLK_WIN_OPEN_MAX_CYC))
        else $error("clock window opened late");
    chk_window_close: assert property (
        $rose(st_reg.state == CSS_ACTIVE)
        |-> st_reg.act_cnt >= ACT_CNT_W'(CLK_WIN_CLOSE_MIN_CYC) && !o_card_rst)
        else $error("clock window closed early");
    chk_clk_duty: assert property (
        $rose(o_card_clk) && st_reg.div_k == 2'h2
        |-> o_card_clk [*2] ##1 !o_card_clk)
        else $error("card clock duty wrong");
    chk_step_unit: assert property (
        half_tick |-> st_reg.gap_cnt == GW'(HALF_STEP_TICKS * OSC_DIVIDE - 1))
        else $error("half step spacing wrong");
    chk_req_deact: assert property (
        st_reg.state == CSS_ACTIVE && st_reg.req_n_s2
        |=> st_reg.state == CSS_DEACTIVATE && !o_card_rst)
        else $error("release did not deactivate");
    chk_sync_path: assert property (
        ##3 st_reg.req_n_s2 == $past(i_activation_request_n, 2))
        else $error("request synchroniser broken");
endmodule : css_sequencer

// ==== tb/css_host_model.sv ====
// Host microcontroller model driving the session command lines
`timescale 1ns/1ps
module css_host_model
(
    // Clock
    input wire logic i_clk,
    // Bench commands
    input wire logic i_start,
    input wire logic i_force,
    input wire logic i_rst_level,
    // Device and card state
    input wire logic i_supply_ready,
    input wire logic i_card_seen,
    // Command lines
    output logic o_activation_request_n,
    output logic o_card_reset_request
);
    // Idle levels from time zero
    initial
    begin
        o_activation_request_n = 1'b1;
        o_card_reset_request = 1'b0;
    end

    // Requests only when allowed, unless the bench orders misbehaviour
    always @(posedge i_clk)
    begin
        o_card_reset_request <= i_rst_level;
        if (!i_start)
            o_activation_request_n <= 1'b1;
        else if (i_force || (i_supply_ready && i_card_seen))
            o_activation_request_n <= 1'b0;
    end
endmodule : css_host_model

// ==== tb/css_sequencer_bench.sv ====
// Self-checking bench for the card session supply sequencer
`timescale 1ns/1ps
module css_sequencer_bench;
    import css_pkg::*;
    // Short reset pulse keeps the run brief; oscillator kept at 40
    localparam int PULSE = 50;
    localparam int OSC = 40;
    localparam int HALF = HALF_STEP_TICKS * OSC;
    localparam int S_VCC = 0, S_IO = 1, S_CLK = 2, S_RST = 3;
    localparam int S_RDY = 4, S_IRQ = 5, S_REQ = 6;
    // Stimulus and observed signals
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, req_n, rst_req;
    logic vcc, io, cclk, crst, rdy, irq;
    logic card_present_in = 1'b0;
    logic card_present_in_n = 1'b1;
    logic [1:0] above = 2'h0;
    logic [1:0] below = 2'h3;
    logic start = 1'b0;
    logic misbehave = 1'b0;
    logic rst_lvl = 1'b0;
    int err_total = 0;
    int tests_run = 0;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    css_sequencer #(.RESET_PULSE_CYCLES(PULSE), .OSC_DIVIDE(OSC)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_activation_request_n(req_n),
        .i_card_reset_request(rst_req), .i_card_present_in(card_present_in),
        .i_card_present_in_n(card_present_in_n), .i_supply_above_upper(above),
        .i_supply_below_lower(below), .o_card_vcc_en(vcc),
        .o_card_io_en(io), .o_card_clk(cclk), .o_card_rst(crst),
        .o_supply_ready(rdy), .o_irq(irq));

    css_host_model host (
        .i_clk(i_clk), .i_start(start), .i_force(misbehave),
        .i_rst_level(rst_lvl), .i_supply_ready(rdy),
        .i_card_seen(card_present_in | !card_present_in_n), .o_activation_request_n(req_n),
        .o_card_reset_request(rst_req));

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input string w, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", w, exp, got);
            err_total++;
        end
    endtask : chk

    // Range check reports the lower bound as the expected value
    task automatic inr(input string w, input int lo, input int hi,
                       input int got);
        chk(w, 32'(lo), (got >= lo && got <= hi) ? 32'(lo) : 32'(got));
    endtask : inr

    function automatic logic pick(input int s);
        case (s)
            S_VCC: pick = vcc;
            S_IO: pick = io;
            S_CLK: pick = cclk;
            S_RST: pick = crst;
            S_RDY: pick = rdy;
            S_IRQ: pick = irq;
            default: pick = req_n;
        endcase
    endfunction : pick

    // Bounded wait; running out ends the run as a mismatch
    task automatic wait_lvl(input int s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (pick(s) !== v && n < lim)
        begin
            @(negedge i_clk);
            n++;
        end
        if (pick(s) !== v)
        begin
            $display("MISMATCH wait %0d expected %b seen %b", s, v, pick(s));
            err_total++;
            stop_test();
        end
    endtask : wait_lvl

    task automatic stays(input int s, input logic v, input int cyc,
                         input string w);
        int bad;
        bad = 0;
        repeat (cyc)
        begin
            @(negedge i_clk);
            if (pick(s) !== v)
                bad++;
        end
        chk(w, 32'h0, 32'(bad));
    endtask : stays

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        @(posedge i_clk);
        while (o_pready !== 1'b1 && n < 50)
        begin
            @(posedge i_clk);
            n++;
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 50)
        begin
            $display("MISMATCH pready expected 1 seen 0");
            err_total++;
            stop_test();
        end
    endtask : apb

    task automatic t_reset();
        logic [31:0] d;
        logic e;
        chk("contacts after reset", 32'h0,
            {26'h0, vcc, io, cclk, crst, rdy, irq});
        apb(1'b0, CTRL_OFFSET, 32'h0, d, e);
        chk("ctrl reset value", 32'h0, d);
        apb(1'b0, 8'h10, 32'h0, d, e);
        chk("unmapped read error", 32'h1, 32'(e));
        chk("unmapped read data", 32'h0, d);
        apb(1'b1, INT_MASK_OFFSET, 32'h7, d, e);
        apb(1'b0, INT_MASK_OFFSET, 32'h0, d, e);
        chk("mask readback", 32'h7, d);
    endtask : t_reset

    // Request held low through low supply and part of the reset pulse, then released before ready
    task automatic t_low_supply();
        int n;
        @(posedge i_clk);
        misbehave <= 1'b1;
        start <= 1'b1;
        card_present_in <= 1'b1;
        stays(S_VCC, 1'b0, 100, "vcc_en under low supply");
        chk("ready under low supply", 32'h0, 32'(rdy));
        @(posedge i_clk);
        above <= 2'h3;
        below <= 2'h0;
        stays(S_VCC, 1'b0, PULSE - 20, "vcc_en in pulse");
        @(posedge i_clk);
        start <= 1'b0;
        wait_lvl(S_RDY, 1'b1, 40, n);
        inr("reset pulse length", PULSE - 2, PULSE + 8,
            PULSE - 19 + n);
        stays(S_VCC, 1'b0, 20, "vcc_en after pulse");
    endtask : t_low_supply

    task automatic t_act();
        int n, t;
        logic [31:0] d;
        logic e;
        @(posedge i_clk);
        start <= 1'b1;
        card_present_in <= 1'b0;
        stays(S_VCC, 1'b0, 100, "vcc_en with no card");
        @(posedge i_clk);
        start <= 1'b0;
        misbehave <= 1'b0;
        rst_lvl <= 1'b1;
        repeat (10) @(posedge i_clk);
        card_present_in_n <= 1'b0;
        start <= 1'b1;
        wait_lvl(S_REQ, 1'b0, 4, n);
        wait_lvl(S_VCC, 1'b1, 8, t);
        wait_lvl(S_IO, 1'b1, 14000, n);
        t += n;
        inr("io_en delay", 8 * HALF, 8 * HALF + 8, t);
        inr("window open", 0, CLK_WIN_OPEN_MAX_CYC, t);
        stays(S_CLK, 1'b0, 200, "clock held by reset");
        @(posedge i_clk);
        rst_lvl <= 1'b0;
        wait_lvl(S_CLK, 1'b1, 24, n);
        t += 201 + n;
        @(posedge i_clk);
        rst_lvl <= 1'b1;
        wait_lvl(S_RST, 1'b1, 9000, n);
        t += n + 1;
        inr("window close", CLK_WIN_CLOSE_MIN_CYC,
            14 * HALF + 10, t);
        inr("reset enable", 14 * HALF, 14 * HALF + 10, t);
        wait_lvl(S_IRQ, 1'b1, 8, n);
        apb(1'b0, INT_STATUS_OFFSET, 32'h0, d, e);
        chk("activation flag", 32'h1, d);
        // Active, supply ok, card present, clock gate on
        apb(1'b0, STATUS_OFFSET, 32'h0, d, e);
        chk("status when active", 32'hd2, d);
        apb(1'b1, INT_STATUS_OFFSET, 32'h1, d, e);
        wait_lvl(S_IRQ, 1'b0, 4, n);
    endtask : t_act

    task automatic t_duty();
        int n, h, l;
        logic [31:0] d;
        logic e;
        logic [1:0] code [3] = '{DIV_SEL_8, DIV_SEL_4, DIV_SEL_2};
        int per [3] = '{8, 4, 2};
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, CTRL_OFFSET, 32'(code[k]) << CTRL_DIV_LSB, d, e);
            repeat (30) @(negedge i_clk);
            wait_lvl(S_CLK, 1'b0, 20, n);
            wait_lvl(S_CLK, 1'b1, 20, n);
            wait_lvl(S_CLK, 1'b0, 20, h);
            wait_lvl(S_CLK, 1'b1, 20, l);
            chk("card clock period", 32'(per[k]), 32'(h + l));
            inr("card clock high", 45 * per[k],
                55 * per[k], 100 * h);
        end
    endtask : t_duty

    task automatic t_deact();
        int n, t;
        logic [31:0] d;
        logic e;
        @(posedge i_clk);
        start <= 1'b0;
        wait_lvl(S_REQ, 1'b1, 4, n);
        wait_lvl(S_RST, 1'b0, 6, t);
        wait_lvl(S_IO, 1'b0, 3000, n);
        t += n;
        chk("vcc_en at io_en off", 32'h1, 32'(vcc));
        chk("clock at io_en off", 32'h0, 32'(cclk));
        inr("io_en off delay", 2 * HALF - 2, 2 * HALF + 8, t);
        wait_lvl(S_VCC, 1'b0, 1400, n);
        inr("vcc_en off delay", 3 * HALF - 2,
            3 * HALF + 8, t + n);
        apb(1'b0, INT_STATUS_OFFSET, 32'h0, d, e);
        chk("deactivation flag", 32'h2, d);
        apb(1'b1, INT_STATUS_OFFSET, 32'h2, d, e);
    endtask : t_deact

    // Supply lost in mid activation
    task automatic t_brown();
        int n;
        logic [31:0] d;
        logic e;
        apb(1'b1, INT_MASK_OFFSET, 32'h0, d, e);
        // Alternate threshold selected; only its comparator pair drops
        apb(1'b1, CTRL_OFFSET, (32'(DIV_SEL_2) << CTRL_DIV_LSB) | 32'h1,
            d, e);
        @(posedge i_clk);
        start <= 1'b1;
        wait_lvl(S_VCC, 1'b1, 12, n);
        repeat (500) @(posedge i_clk);
        above <= 2'h1;
        below <= 2'h2;
        wait_lvl(S_RDY, 1'b0, 8, n);
        wait_lvl(S_VCC, 1'b0, 3 * HALF + 12, n);
        chk("contacts off", 32'h0, {29'h0, io, cclk, crst});
        stays(S_VCC, 1'b0, 200, "vcc_en with supply low");
        apb(1'b0, INT_STATUS_OFFSET, 32'h0, d, e);
        chk("supply fault flag", 32'h1,
            32'(d[INT_SUPPLY_FAULT_BIT]));
        chk("masked irq", 32'h0, 32'(irq));
        apb(1'b1, INT_MASK_OFFSET, 32'h4, d, e);
        wait_lvl(S_IRQ, 1'b1, 4, n);
        apb(1'b1, INT_STATUS_OFFSET, 32'h7, d, e);
        wait_lvl(S_IRQ, 1'b0, 4, n);
    endtask : t_brown

    // Main sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_low_supply();
        t_act();
        t_duty();
        t_deact();
        t_brown();
        stop_test();
    end
endmodule : css_sequencer_bench
